/* core/digitizer_bus_control_status.sv */
// Control and status register bank behind the board's bus slave port
`timescale 1ns/10ps
`default_nettype none
module digitizer_bus_control_status
#(
	parameter logic [15:0] BUILD_DATE      = 16'h0000,
	parameter logic [7:0]  REV_MAJOR       = 8'h01,
	parameter logic [7:0]  REV_MINOR       = 8'h00,
	parameter logic [7:0]  MEM_MB_PER_GRP  = 8'h01,
	// Board type code: value is arbitrary
	parameter logic [7:0]  BOARD_TYPE      = 8'h5A,
	parameter bit          BACKPLANE_GEO   = 1'b0
)
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Register access port
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	output logic             reg_rvalid,
	// Readout termination
	input  wire logic        blt_end,
	input  wire logic        d32_empty_read,
	output logic             bus_error,
	output logic             dtack,
	output logic             wide_word_alignment,
	// Interrupt acknowledge and requests
	input  wire logic        iack_cycle,
	input  wire logic [9:0]  irq_event_threshold,
	output logic             vme_irq,
	output logic [2:0]       vme_irq_level,
	output logic             optical_irq,
	// Output buffer state
	input  wire logic        event_stored,
	input  wire logic        event_read,
	input  wire logic [31:0] buffer_limit,
	input  wire logic [31:0] next_length,
	input  wire logic        fifo_empty,
	// Base address
	input  wire logic [15:0] rotary_switch,
	input  wire logic [15:0] relocation_addr,
	output logic [15:0]      base_addr,
	// Slot identifier
	input  wire logic [4:0]  slot_geographic_address,
	output logic [4:0]       header_slot_identifier,
	// Analog monitor
	input  wire logic [11:0] majority_level,
	output logic [11:0]      monitor_code
);

	logic [31:0] count_q;
	logic [31:0] count_d;
	logic [31:0] length_q;
	logic [11:0] dac_q;
	logic [2:0]  mode_q;
	logic [7:0]  ctl_q;
	logic        berr_flag_q;
	logic [4:0]  slot_q;
	logic [11:0] ramp_q;
	logic [11:0] mon_q;
	logic [15:0] base_q;
	logic        berr_q;
	logic        dtack_q;
	logic [31:0] rdata_q;
	logic        rvalid_q;
	logic [15:0] rot_s1_q;
	logic [15:0] rot_s2_q;
	logic [4:0]  geo_s1_q;
	logic [4:0]  geo_s2_q;
	logic        end_event;
	logic        wr_ctl;
	logic        rd_status;
	logic [4:0]  slot_value;
	logic        over_threshold;
	logic        wr_dac;
	logic        wr_mode;
	logic        wr_slot;
	logic        berr_en;

	// Address match for a register access
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	// Clip a 32-bit count to a 12-bit monitor code
	function automatic logic [11:0] clip12(input logic [31:0] v);
		clip12 = (v > 32'h0000_0FFF) ? 12'hFFF : v[11:0];
	endfunction

	assign wr_ctl    = reg_wr && hit(reg_addr, vme_regs_pkg::OFS_BUS_CONTROL);
	assign rd_status = reg_rd && hit(reg_addr, vme_regs_pkg::OFS_BUS_STATUS);
	assign end_event = blt_end || d32_empty_read;
	assign wr_dac    = reg_wr && hit(reg_addr, vme_regs_pkg::OFS_MONITOR_DAC_LEVEL);
	assign wr_mode   = reg_wr && hit(reg_addr, vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT);
	assign wr_slot   = reg_wr && hit(reg_addr, vme_regs_pkg::OFS_SLOT_IDENTIFIER);
	assign berr_en   = ctl_q[vme_regs_pkg::CTL_BERR_EN];

	// Rotary switch synchroniser; pins may move at any time
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rot_s1_q <= 16'h0000;
			rot_s2_q <= 16'h0000;
		end
		else
		begin
			rot_s1_q <= rotary_switch;
			rot_s2_q <= rot_s1_q;
		end
	end

	// Backplane slot pins synchroniser
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			geo_s1_q <= 5'h00;
			geo_s2_q <= 5'h00;
		end
		else
		begin
			geo_s1_q <= slot_geographic_address;
			geo_s2_q <= geo_s1_q;
		end
	end

	// Stored event count, held inside the configured buffer count
	// Store and read in one cycle cancel out
	always_comb
	begin
		count_d = count_q;
		if (event_stored && !event_read && (count_q < buffer_limit))
			count_d = count_q + 32'h0000_0001;
		else if (event_read && !event_stored && (count_q != 32'h0000_0000))
			count_d = count_q - 32'h0000_0001;
		if (count_d > buffer_limit)
			count_d = buffer_limit;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			count_q <= 32'h0000_0000;
		else
			count_q <= count_d;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			length_q <= 32'h0000_0000;
		else
			length_q <= next_length;
	end

	// Writable registers; read-only offsets fall through untouched
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			dac_q <= vme_regs_pkg::DAC_RESET;
		else if (wr_dac)
			dac_q <= reg_wdata[11:0];
	end

	// Reserved mode code is stored as written and decoded to zero below
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			mode_q <= vme_regs_pkg::MON_RESET;
		else if (wr_mode)
			mode_q <= reg_wdata[2:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ctl_q <= vme_regs_pkg::CTL_RESET;
		else if (wr_ctl)
			ctl_q <= reg_wdata[7:0];
	end

	// Slot identifier register; ignored when the backplane supplies it
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			slot_q <= vme_regs_pkg::SLOT_RESET;
		else if (!BACKPLANE_GEO && wr_slot)
			slot_q <= reg_wdata[4:0];
	end

	assign slot_value = BACKPLANE_GEO ? geo_s2_q : slot_q;
	assign header_slot_identifier = slot_value;

	// Bus error flag: a new error in the read cycle survives the clear
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			berr_flag_q <= 1'b0;
		else if (ctl_q[vme_regs_pkg::CTL_BERR_EN] && end_event)
			berr_flag_q <= 1'b1;
		else if (rd_status)
			berr_flag_q <= 1'b0;
	end

	// Readout termination: error only when enabled, acknowledge otherwise
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			berr_q <= 1'b0;
		else
			berr_q <= end_event && berr_en;
	end

	// Exactly one of the two answers per termination, never both
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			dtack_q <= 1'b0;
		else
			dtack_q <= end_event && !berr_en;
	end

	assign bus_error = berr_q;
	assign dtack     = dtack_q;

	// Base address source, registered so the decoder sees a stable value
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			base_q <= 16'h0000;
		else if (ctl_q[vme_regs_pkg::CTL_RELOCATION])
			base_q <= relocation_addr;
		else
			base_q <= rot_s2_q;
	end

	assign base_addr = base_q;
	assign wide_word_alignment = ctl_q[vme_regs_pkg::CTL_ALIGN];
	assign vme_irq_level = ctl_q[vme_regs_pkg::CTL_LEVEL_HI:0];

	// Ramp wraps freely; its rate is one code per clock
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ramp_q <= 12'h000;
		else
			ramp_q <= ramp_q + 12'h001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			mon_q <= 12'h000;
		else
		begin
			unique case (mode_q)
				vme_regs_pkg::MON_MAJORITY:  mon_q <= majority_level;
				vme_regs_pkg::MON_RAMP:      mon_q <= ramp_q;
				vme_regs_pkg::MON_OCCUPANCY: mon_q <= clip12(count_q);
				vme_regs_pkg::MON_LEVEL:     mon_q <= dac_q;
				// Reserved and undefined codes park the output at zero
				default:                     mon_q <= 12'h000;
			endcase
		end
	end

	assign monitor_code = mon_q;

	// Strictly above: a count equal to the threshold stays quiet
	assign over_threshold = count_q > {22'h000000, irq_event_threshold};

	irq_release u_irq
	(
		.ref_clk         (ref_clk),
		.sys_rst         (sys_rst),
		.level           (ctl_q[vme_regs_pkg::CTL_LEVEL_HI:0]),
		.on_acknowledge  (ctl_q[vme_regs_pkg::CTL_RELEASE_MODE]),
		.optical_enable  (ctl_q[vme_regs_pkg::CTL_OPT_IRQ_EN]),
		.ctl_write       (wr_ctl),
		.ctl_write_level (reg_wdata[2:0]),
		.iack_cycle      (iack_cycle),
		.over_threshold  (over_threshold),
		.vme_irq         (vme_irq),
		.optical_irq     (optical_irq)
	);

	// Read valid follows every strobe, mapped or not, so the host never hangs
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rvalid_q <= 1'b0;
		else
			rvalid_q <= reg_rd;
	end

	// Read data, one cycle after the strobe; unmapped offsets read zero
	// Data holds between reads so a slow host may sample late
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rdata_q <= 32'h0000_0000;
		else
		begin
			if (reg_rd)
			begin
				unique case (reg_addr)
					vme_regs_pkg::OFS_FIRMWARE_REVISION:
						rdata_q <= {BUILD_DATE, REV_MAJOR, REV_MINOR};
					vme_regs_pkg::OFS_STORED_EVENT_COUNT:
						rdata_q <= count_q;
					vme_regs_pkg::OFS_MONITOR_DAC_LEVEL:
						rdata_q <= {20'h00000, dac_q};
					vme_regs_pkg::OFS_BOARD_INFORMATION:
						rdata_q <= {16'h0000, MEM_MB_PER_GRP, BOARD_TYPE};
					vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT:
						rdata_q <= {29'h00000000, mode_q};
					vme_regs_pkg::OFS_NEXT_EVENT_LENGTH:
						rdata_q <= length_q;
					vme_regs_pkg::OFS_BUS_CONTROL:
						rdata_q <= {24'h000000, ctl_q};
					vme_regs_pkg::OFS_BUS_STATUS:
						rdata_q <= {28'h0000000, fifo_empty, berr_flag_q, 1'b0,
							count_q != 32'h0000_0000};
					vme_regs_pkg::OFS_SLOT_IDENTIFIER:
						rdata_q <= {27'h0000000, slot_value};
					default:
						rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

endmodule
`default_nettype wire

/* core/vme_regs_pkg.sv */
// Register map, field positions and reset values of the board control and status bank
package vme_regs_pkg;

	localparam logic [15:0] OFS_FIRMWARE_REVISION     = 16'h8124;
	localparam logic [15:0] OFS_STORED_EVENT_COUNT    = 16'h812C;
	localparam logic [15:0] OFS_MONITOR_DAC_LEVEL     = 16'h8138;
	localparam logic [15:0] OFS_BOARD_INFORMATION     = 16'h8140;
	localparam logic [15:0] OFS_MONITOR_SOURCE_SELECT = 16'h8144;
	localparam logic [15:0] OFS_NEXT_EVENT_LENGTH     = 16'h814C;
	localparam logic [15:0] OFS_BUS_CONTROL           = 16'hEF00;
	localparam logic [15:0] OFS_BUS_STATUS            = 16'hEF04;
	localparam logic [15:0] OFS_SLOT_IDENTIFIER       = 16'hEF08;

	// Bus control fields
	localparam int CTL_RELEASE_MODE = 7;
	localparam int CTL_RELOCATION   = 6;
	localparam int CTL_ALIGN        = 5;
	localparam int CTL_BERR_EN      = 4;
	localparam int CTL_OPT_IRQ_EN   = 3;
	localparam int CTL_LEVEL_HI     = 2;
	localparam int CTL_WIDTH        = 8;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// Bus status fields
	localparam int STS_FIFO_EMPTY  = 3;
	localparam int STS_BERR_FLAG   = 2;
	localparam int STS_EVENT_READY = 0;

	// Monitor
	localparam int DAC_WIDTH = 12;
	localparam logic [11:0] DAC_RESET = 12'h000;
	localparam logic [2:0] MON_MAJORITY  = 3'h0;
	localparam logic [2:0] MON_RAMP      = 3'h1;
	localparam logic [2:0] MON_RESERVED  = 3'h2;
	localparam logic [2:0] MON_OCCUPANCY = 3'h3;
	localparam logic [2:0] MON_LEVEL     = 3'h4;
	localparam logic [2:0] MON_RESET     = 3'h0;

	// Slot identifier
	localparam int SLOT_WIDTH = 5;
	localparam logic [4:0] SLOT_RESET = 5'h00;

	// Event threshold width
	localparam int THR_WIDTH = 10;

endpackage

/* core/irq_release.sv */
// Interrupt request generation and release for backplane and optical link
`timescale 1ns/10ps
`default_nettype none
module irq_release
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Control settings
	input  wire logic [2:0] level,
	input  wire logic       on_acknowledge,
	input  wire logic       optical_enable,
	// Events
	input  wire logic       ctl_write,
	input  wire logic [2:0] ctl_write_level,
	input  wire logic       iack_cycle,
	input  wire logic       over_threshold,
	// Requests
	output logic            vme_irq,
	output logic            optical_irq
);

	logic armed_q;
	logic vme_q;
	logic opt_q;
	logic vme_release;
	logic opt_release;
	logic level_zero_write;

	assign level_zero_write = ctl_write && (ctl_write_level == 3'h0);
	assign vme_release = on_acknowledge ? iack_cycle : level_zero_write;
	// Optical requests ignore the release mode bit
	assign opt_release = level_zero_write;

	// Rearmed only by a nonzero level write; releasing a pending request disarms
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			armed_q <= 1'b0;
		else if (ctl_write && (ctl_write_level != 3'h0))
			armed_q <= 1'b1;
		else if ((vme_q && vme_release) || (opt_q && opt_release))
			armed_q <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			vme_q <= 1'b0;
		else if (vme_release)
			vme_q <= 1'b0;
		else if (armed_q && (level != 3'h0) && over_threshold)
			vme_q <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			opt_q <= 1'b0;
		else if (opt_release)
			opt_q <= 1'b0;
		else if (armed_q && optical_enable && (level != 3'h0) && over_threshold)
			opt_q <= 1'b1;
	end

	assign vme_irq     = vme_q;
	assign optical_irq = opt_q;

endmodule
`default_nettype wire

/* dv/regs_monitor.sv */
// Port-level timing checks of the control and status register bank
`timescale 1ns/10ps
`default_nettype none
module regs_monitor
#(
	parameter bit BACKPLANE_GEO = 1'b0
)
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_rvalid,
	// Termination, alignment, interrupts
	input wire logic        blt_end,
	input wire logic        d32_empty_read,
	input wire logic        bus_error,
	input wire logic        dtack,
	input wire logic        wide_word_alignment,
	input wire logic        vme_irq,
	input wire logic [2:0]  vme_irq_level,
	// Buffer, address, slot
	input wire logic        fifo_empty,
	input wire logic [15:0] relocation_addr,
	input wire logic [15:0] base_addr,
	input wire logic [4:0]  header_slot_identifier
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic term;
	logic ctl_wr;
	logic sts_rd;
	assign term = blt_end || d32_empty_read;
	assign ctl_wr = reg_wr && reg_addr == vme_regs_pkg::OFS_BUS_CONTROL;
	assign sts_rd = reg_rd && reg_addr == vme_regs_pkg::OFS_BUS_STATUS;

	read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	term_answer_a: assert property (term |=> bus_error ^ dtack) else $error("bad end");
	term_quiet_a: assert property (!term |=> !bus_error && !dtack) else $error("stray end");
	align_bit_a: assert property (ctl_wr |=> wide_word_alignment == $past(reg_wdata[5]))
		else $error("alignment mismatch");
	irq_level_a: assert property (ctl_wr |=> vme_irq_level == $past(reg_wdata[2:0]))
		else $error("level mismatch");
	level_zero_a: assert property (vme_irq_level == 3'h0 |=> !vme_irq)
		else $error("irq at level zero");
	base_address_relocation_base_a: assert property (ctl_wr && reg_wdata[6] ##1 !reg_wr
		|=> base_addr == $past(relocation_addr)) else $error("base not relocated");
	fifo_bit_a: assert property (sts_rd |=> reg_rdata[3] == $past(fifo_empty))
		else $error("fifo bit wrong");
	status_rsvd_a: assert property (sts_rd |=> reg_rdata[31:4] == 28'h0 && !reg_rdata[1])
		else $error("status reserved set");
	berr_clear_a: assert property (sts_rd && !term ##1 sts_rd |=> !reg_rdata[2])
		else $error("error flag kept");
	slot_write_a: assert property (!BACKPLANE_GEO && reg_wr
		&& reg_addr == vme_regs_pkg::OFS_SLOT_IDENTIFIER
		|=> header_slot_identifier == $past(reg_wdata[4:0])) else $error("slot mismatch");
	unmapped_zero_a: assert property (reg_rd && reg_addr == 16'h0000 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	cover property (term ##1 bus_error);
	cover property (vme_irq);
	cover property (sts_rd ##1 reg_rdata[2]);
endmodule
bind digitizer_bus_control_status regs_monitor #(.BACKPLANE_GEO(BACKPLANE_GEO)) mon (.*);
`default_nettype wire

/* dv/vme_host_model.sv */
// Bus master model driving the register port of the bank
`timescale 1ns/10ps
`default_nettype none
module vme_host_model
(
	// Clock
	input  wire logic        ref_clk,
	// Register port
	output logic [15:0]      reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	initial
	begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		// Released data lines must not keep the last word
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench of the control and status register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] reg_addr;
	logic reg_wr, reg_rd, reg_rvalid, bus_error, dtack, wide_word_alignment;
	logic [31:0] reg_wdata, reg_rdata;
	logic blt_end = 1'b0, d32_empty_read = 1'b0, iack_cycle = 1'b0;
	logic [9:0] irq_event_threshold = 10'h001;
	logic vme_irq, optical_irq, event_stored = 1'b0, event_read = 1'b0, fifo_empty = 1'b1;
	logic [2:0] vme_irq_level;
	logic [31:0] buffer_limit = 32'h3, next_length = 32'h123;
	logic [15:0] rotary_switch = 16'h3C5A, relocation_addr = 16'hA5C3, base_addr;
	logic [4:0] slot_geographic_address = 5'h0B, header_slot_identifier;
	logic [11:0] majority_level = 12'h5C3, monitor_code, a;
	int num_errors = 0;
	int total_checks = 0;
	always #4 ref_clk = ~ref_clk;

	// Board type value is arbitrary
	digitizer_bus_control_status #(.BUILD_DATE(16'h2B17), .REV_MAJOR(8'h03),
		.REV_MINOR(8'h0C), .MEM_MB_PER_GRP(8'h40), .BOARD_TYPE(8'h5A)) uut (.*);
	vme_host_model host (.*);

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rc(input logic [15:0] adr, input logic [31:0] e);
		logic [31:0] d;
		host.rd(adr, d);
		chk($sformatf("reg %h", adr), d, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic t_ident_monitor;
		rc(vme_regs_pkg::OFS_FIRMWARE_REVISION, 32'h2B17030C);
		rc(vme_regs_pkg::OFS_BOARD_INFORMATION, 32'h0000405A);
		rc(vme_regs_pkg::OFS_BUS_STATUS, 32'h8);
		rc(vme_regs_pkg::OFS_SLOT_IDENTIFIER, 32'h0);
		host.wr(vme_regs_pkg::OFS_FIRMWARE_REVISION, 32'h0);
		rc(vme_regs_pkg::OFS_FIRMWARE_REVISION, 32'h2B17030C);
		host.wr(vme_regs_pkg::OFS_MONITOR_DAC_LEVEL, 32'hFFFFFABC);
		rc(vme_regs_pkg::OFS_MONITOR_DAC_LEVEL, 32'hABC);
		host.wr(vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT, 32'h4);
		cyc(1);
		chk("monitor", monitor_code, 12'hABC);
		host.wr(vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT, 32'h0);
		cyc(1);
		chk("monitor", monitor_code, 12'h5C3);
		host.wr(vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT, 32'h2);
		cyc(1);
		chk("monitor", monitor_code, 12'h0);
		host.wr(vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT, 32'h1);
		cyc(1);
		a = monitor_code;
		cyc(1);
		chk("ramp", monitor_code, a + 12'h1);
	endtask

	task automatic t_events_irq;
		event_stored = 1'b1;
		cyc(5);
		event_stored = 1'b0;
		rc(vme_regs_pkg::OFS_STORED_EVENT_COUNT, 32'h3);
		rc(vme_regs_pkg::OFS_NEXT_EVENT_LENGTH, 32'h123);
		host.wr(vme_regs_pkg::OFS_MONITOR_SOURCE_SELECT, 32'h3);
		cyc(1);
		chk("occupancy", monitor_code, 12'h3);
		event_read = 1'b1;
		cyc(1);
		event_read = 1'b0;
		rc(vme_regs_pkg::OFS_STORED_EVENT_COUNT, 32'h2);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h08);
		cyc(2);
		chk("irq", {vme_irq, optical_irq}, 2'b00);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h09);
		cyc(1);
		chk("irq", {vme_irq, optical_irq, vme_irq_level}, 5'h19);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h0);
		cyc(3);
		chk("irq", {vme_irq, optical_irq}, 2'b00);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h8B);
		cyc(1);
		rc(vme_regs_pkg::OFS_BUS_CONTROL, 32'h8B);
		iack_cycle = 1'b1;
		cyc(1);
		iack_cycle = 1'b0;
		cyc(3);
		chk("irq", {vme_irq, optical_irq}, 2'b01);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h0);
		cyc(1);
		chk("optical", optical_irq, 1'b0);
	endtask

	task automatic t_berr_misc;
		blt_end = 1'b1;
		cyc(1);
		blt_end = 1'b0;
		chk("end", {bus_error, dtack}, 2'b01);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h10);
		fifo_empty = 1'b0;
		d32_empty_read = 1'b1;
		cyc(1);
		d32_empty_read = 1'b0;
		chk("end", {bus_error, dtack}, 2'b10);
		rc(vme_regs_pkg::OFS_BUS_STATUS, 32'h5);
		rc(vme_regs_pkg::OFS_BUS_STATUS, 32'h1);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h60);
		cyc(1);
		chk("base", {wide_word_alignment, base_addr}, 17'h1A5C3);
		host.wr(vme_regs_pkg::OFS_BUS_CONTROL, 32'h0);
		cyc(1);
		chk("base", {wide_word_alignment, base_addr}, 17'h03C5A);
		host.wr(vme_regs_pkg::OFS_SLOT_IDENTIFIER, 32'hFFFFFFFF);
		chk("header", header_slot_identifier, 5'h1F);
		rc(vme_regs_pkg::OFS_SLOT_IDENTIFIER, 32'h1F);
		rc(16'h0000, 32'h0);
	endtask

	initial
	begin
		cyc(10);
		sys_rst = 1'b0;
		t_ident_monitor();
		t_events_irq();
		t_berr_misc();
		tally_and_finish();
	end
	initial
	begin
		#20000;
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
